// file: rtl/psdl_params.svh
/*
  Constants of the port strap default loader: register offsets, field
  positions, reset values and the strap settling count.
  Assumes it is included by bare name from the loader module and the bench files.
*/
`ifndef PSDL_PARAMS_SVH
`define PSDL_PARAMS_SVH

// Byte offsets of the APB registers.
`define PSDL_OFS_P1_FLOWCTL 12'h000
`define PSDL_OFS_P1_ADVERT 12'h004
`define PSDL_OFS_P2_BASIC 12'h008
`define PSDL_OFS_P2_ADVERT 12'h00c
`define PSDL_OFS_P2_SPECIAL 12'h010
`define PSDL_OFS_P2_MODES 12'h014
`define PSDL_OFS_STRAPS 12'h018

// Field positions.
`define PSDL_B_MANUAL_SEL 0
`define PSDL_B_TX_PAUSE 1
`define PSDL_B_RX_PAUSE 2
`define PSDL_B_SYM_PAUSE 10
`define PSDL_B_ADV_10FD 6
`define PSDL_B_ADV_10HD 5
`define PSDL_B_AN_EN 12
`define PSDL_B_SPEED_LSB 13
`define PSDL_B_DUPLEX 8
`define PSDL_B_XOVER_OVR 15
`define PSDL_B_SW_AUTO 14
`define PSDL_B_SW_MDIX 13
`define PSDL_B_EFF_AUTO 1
`define PSDL_B_EFF_MDIX 0

// Strap vector bit order.
`define PSDL_S_P1_MANUAL 0
`define PSDL_S_P1_FDPAUSE 1
`define PSDL_S_P2_AUTO 2
`define PSDL_S_P2_MANUAL 3
`define PSDL_S_P2_AN 4
`define PSDL_S_P2_SPEED 5

// Reset values: strap defaults and bits without a strap.
`define PSDL_STRAP_RST 6'h36
`define PSDL_DUPLEX_RST 1'h1
`define PSDL_MODE_AUTONEG 3'h7

// Final settle count: the strap synchroniser is given this many cycles plus one to settle after reset release.
`define PSDL_SETTLE_CYCLES 2'h3

`endif

// file: rtl/psdl_pkg.sv
/*
  Types of the port strap default loader: the loader state and the
  packed struct that holds all state of the module.
  Assumes psdl_params.svh is on the include path.
*/
package psdl_pkg;
  typedef enum logic [2:0] {
    PSDL_SETTLE = 3'b001,
    PSDL_LOAD = 3'b010,
    PSDL_RUN = 3'b100
  } psdl_state_t;

  typedef struct packed {
    psdl_state_t st;
    logic [1:0] settle_cnt;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [5:0] straps;
    logic loaded;
    logic p1_manual_sel;
    logic p1_pause_auto;
    logic p1_tx_pause;
    logic p1_rx_pause;
    logic p1_sym_pause;
    logic p2_an;
    logic p2_speed;
    logic p2_duplex;
    logic p2_adv_10fd;
    logic p2_adv_10hd;
    logic [2:0] p2_mode;
    logic p2_xover_ovr;
    logic p2_sw_auto;
    logic p2_sw_mdix;
    logic p2_auto_eff;
    logic p2_mdix_eff;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } psdl_regs_t;
endpackage : psdl_pkg

// file: rtl/psdl_loader.sv
/*
  Port strap default loader: synchronises the strap pins, loads them as
  the defaults of the port 1 flow-control bits and the port 2 PHY
  control, advertisement and mode bits, and serves them over APB.
  Assumes strap pins are static around reset and may come from any
  clock domain; pclk runs at 250 MHz.
*/
`timescale 1ns/1ps
`include "psdl_params.svh"

module psdl_loader
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic p1_manual_flowctl_strap,
  input wire logic p1_fullduplex_pause_strap,
  input wire logic p2_auto_xover_strap,
  input wire logic p2_manual_xover_strap,
  input wire logic p2_autoneg_strap,
  input wire logic p2_speed_strap,
  output logic defaults_loaded,
  output logic p1_manual_flowctl_select,
  output logic p1_pause_from_autoneg,
  output logic p1_tx_pause_enable,
  output logic p1_rx_pause_enable,
  output logic p1_sym_pause_advert,
  output logic p2_autoneg_enable,
  output logic p2_speed_select_low,
  output logic p2_duplex_select,
  output logic p2_advert_10fd,
  output logic p2_advert_10hd,
  output logic [2:0] p2_phy_mode,
  output logic p2_auto_xover_active,
  output logic p2_mdix_select
);
  import psdl_pkg::*;

  psdl_regs_t cur_ff;
  psdl_regs_t nxt_regs;

  // Merge write data into an old word, honouring the byte strobes.
  function automatic logic [31:0] psdl_merge
  (
    input logic [31:0] old_w,
    input logic [31:0] new_w,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction : psdl_merge

  // Strap-derived defaults; applied only once, in the load state,
  // from the synchronised strap vector.
  function automatic psdl_regs_t psdl_defaults
  (
    input psdl_regs_t r,
    input logic [5:0] s
  );
    psdl_regs_t o;
    o = r;
    o.p1_manual_sel = s[`PSDL_S_P1_MANUAL];
    o.p1_pause_auto = ~s[`PSDL_S_P1_MANUAL];
    o.p1_sym_pause = ~s[`PSDL_S_P1_MANUAL];
    o.p1_tx_pause = s[`PSDL_S_P1_FDPAUSE];
    o.p1_rx_pause = s[`PSDL_S_P1_FDPAUSE];
    o.p2_an = s[`PSDL_S_P2_AN];
    o.p2_speed = s[`PSDL_S_P2_SPEED];
    o.p2_duplex = `PSDL_DUPLEX_RST;
    // Auto-negotiation advertises every 10BASE-T ability; a forced link
    // advertises 10BASE-T only when it is forced to 10 Mbps.
    o.p2_adv_10fd = s[`PSDL_S_P2_AN] | ~s[`PSDL_S_P2_SPEED];
    o.p2_adv_10hd = s[`PSDL_S_P2_AN] | ~s[`PSDL_S_P2_SPEED];
    if (s[`PSDL_S_P2_AN])
    begin
      o.p2_mode = `PSDL_MODE_AUTONEG;
    end
    else
    begin
      o.p2_mode = {1'b0, s[`PSDL_S_P2_SPEED], `PSDL_DUPLEX_RST};
    end
    o.p2_xover_ovr = 1'b0;
    o.p2_sw_auto = s[`PSDL_S_P2_AUTO];
    o.p2_sw_mdix = s[`PSDL_S_P2_MANUAL];
    return o;
  endfunction : psdl_defaults

  // Read mux of the register map.
  function automatic logic [31:0] psdl_read
  (
    input psdl_regs_t r,
    input logic [11:0] addr
  );
    logic [31:0] d;
    d = 32'h0;
    unique case (addr)
      `PSDL_OFS_P1_FLOWCTL:
      begin
        d[`PSDL_B_MANUAL_SEL] = r.p1_manual_sel;
        d[`PSDL_B_TX_PAUSE] = r.p1_tx_pause;
        d[`PSDL_B_RX_PAUSE] = r.p1_rx_pause;
      end
      `PSDL_OFS_P1_ADVERT:
      begin
        d[`PSDL_B_SYM_PAUSE] = r.p1_sym_pause;
      end
      `PSDL_OFS_P2_BASIC:
      begin
        d[`PSDL_B_AN_EN] = r.p2_an;
        d[`PSDL_B_SPEED_LSB] = r.p2_speed;
        d[`PSDL_B_DUPLEX] = r.p2_duplex;
      end
      `PSDL_OFS_P2_ADVERT:
      begin
        d[`PSDL_B_ADV_10FD] = r.p2_adv_10fd;
        d[`PSDL_B_ADV_10HD] = r.p2_adv_10hd;
      end
      `PSDL_OFS_P2_SPECIAL:
      begin
        d[`PSDL_B_XOVER_OVR] = r.p2_xover_ovr;
        d[`PSDL_B_SW_AUTO] = r.p2_sw_auto;
        d[`PSDL_B_SW_MDIX] = r.p2_sw_mdix;
        d[`PSDL_B_EFF_AUTO] = r.p2_auto_eff;
        d[`PSDL_B_EFF_MDIX] = r.p2_mdix_eff;
      end
      `PSDL_OFS_P2_MODES:
      begin
        d[2:0] = r.p2_mode;
      end
      `PSDL_OFS_STRAPS:
      begin
        d[5:0] = r.straps;
      end
      default:
      begin
        d = 32'h0;
      end
    endcase
    return d;
  endfunction : psdl_read

  function automatic logic psdl_mapped
  (
    input logic [11:0] addr
  );
    return (addr == `PSDL_OFS_P1_FLOWCTL) || (addr == `PSDL_OFS_P1_ADVERT) ||
           (addr == `PSDL_OFS_P2_BASIC) || (addr == `PSDL_OFS_P2_ADVERT) ||
           (addr == `PSDL_OFS_P2_SPECIAL) || (addr == `PSDL_OFS_P2_MODES) ||
           (addr == `PSDL_OFS_STRAPS);
  endfunction : psdl_mapped

  always_comb
  begin
    logic [31:0] wd;
    logic do_write;
    wd = 32'h0;
    do_write = 1'b0;
    nxt_regs = cur_ff;
    nxt_regs.sync1 = {p2_speed_strap, p2_autoneg_strap, p2_manual_xover_strap,
                      p2_auto_xover_strap, p1_fullduplex_pause_strap,
                      p1_manual_flowctl_strap};
    nxt_regs.sync2 = cur_ff.sync1;
    nxt_regs.pready = 1'b0;
    nxt_regs.pslverr = 1'b0;
    unique case (cur_ff.st)
      PSDL_SETTLE:
      begin
        // The straps are only sampled once both synchroniser stages hold
        // post-reset pin levels.
        nxt_regs.settle_cnt = cur_ff.settle_cnt + 2'h1;
        if (cur_ff.settle_cnt == `PSDL_SETTLE_CYCLES)
        begin
          nxt_regs.st = PSDL_LOAD;
        end
      end
      PSDL_LOAD:
      begin
        nxt_regs = psdl_defaults(nxt_regs, cur_ff.sync2);
        nxt_regs.straps = cur_ff.sync2;
        nxt_regs.loaded = 1'b1;
        nxt_regs.st = PSDL_RUN;
      end
      PSDL_RUN:
      begin
        // Straps are frozen from here; later pin changes have no effect.
        if (psel && !cur_ff.pready)
        begin
          nxt_regs.pready = 1'b1;
          nxt_regs.pslverr = !psdl_mapped(paddr) ||
                             (pwrite && (paddr == `PSDL_OFS_STRAPS));
          nxt_regs.prdata = pwrite ? 32'h0 : psdl_read(cur_ff, paddr);
        end
        do_write = cur_ff.pready && psel && penable && pwrite;
        if (do_write)
        begin
          wd = psdl_merge(psdl_read(cur_ff, paddr), pwdata, pstrb);
          unique case (paddr)
            `PSDL_OFS_P1_FLOWCTL:
            begin
              nxt_regs.p1_manual_sel = wd[`PSDL_B_MANUAL_SEL];
              nxt_regs.p1_pause_auto = ~wd[`PSDL_B_MANUAL_SEL];
              nxt_regs.p1_tx_pause = wd[`PSDL_B_TX_PAUSE];
              nxt_regs.p1_rx_pause = wd[`PSDL_B_RX_PAUSE];
            end
            `PSDL_OFS_P1_ADVERT:
            begin
              nxt_regs.p1_sym_pause = wd[`PSDL_B_SYM_PAUSE];
            end
            `PSDL_OFS_P2_BASIC:
            begin
              nxt_regs.p2_an = wd[`PSDL_B_AN_EN];
              nxt_regs.p2_speed = wd[`PSDL_B_SPEED_LSB];
              nxt_regs.p2_duplex = wd[`PSDL_B_DUPLEX];
            end
            `PSDL_OFS_P2_ADVERT:
            begin
              nxt_regs.p2_adv_10fd = wd[`PSDL_B_ADV_10FD];
              nxt_regs.p2_adv_10hd = wd[`PSDL_B_ADV_10HD];
            end
            `PSDL_OFS_P2_SPECIAL:
            begin
              nxt_regs.p2_xover_ovr = wd[`PSDL_B_XOVER_OVR];
              nxt_regs.p2_sw_auto = wd[`PSDL_B_SW_AUTO];
              nxt_regs.p2_sw_mdix = wd[`PSDL_B_SW_MDIX];
            end
            `PSDL_OFS_P2_MODES:
            begin
              nxt_regs.p2_mode = wd[2:0];
            end
            default:
            begin
              nxt_regs.p2_mode = nxt_regs.p2_mode;
            end
          endcase
        end
      end
      default:
      begin
        nxt_regs.st = PSDL_SETTLE;
      end
    endcase
    // The effective crossover follows the stored state of the next cycle,
    // so a write to the override shows on the pins at the edge that stores it.
    if (nxt_regs.p2_xover_ovr)
    begin
      nxt_regs.p2_auto_eff = nxt_regs.p2_sw_auto;
      nxt_regs.p2_mdix_eff = nxt_regs.p2_sw_mdix;
    end
    else
    begin
      nxt_regs.p2_auto_eff = nxt_regs.straps[`PSDL_S_P2_AUTO];
      nxt_regs.p2_mdix_eff = nxt_regs.straps[`PSDL_S_P2_MANUAL];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cur_ff <= psdl_regs_t'{
        st: PSDL_SETTLE,
        settle_cnt: 2'h0,
        sync1: 6'h0,
        sync2: 6'h0,
        straps: `PSDL_STRAP_RST,
        loaded: 1'b0,
        p1_manual_sel: 1'b0,
        p1_pause_auto: 1'b1,
        p1_tx_pause: 1'b1,
        p1_rx_pause: 1'b1,
        p1_sym_pause: 1'b1,
        p2_an: 1'b1,
        p2_speed: 1'b1,
        p2_duplex: `PSDL_DUPLEX_RST,
        p2_adv_10fd: 1'b1,
        p2_adv_10hd: 1'b1,
        p2_mode: `PSDL_MODE_AUTONEG,
        p2_xover_ovr: 1'b0,
        p2_sw_auto: 1'b1,
        p2_sw_mdix: 1'b0,
        p2_auto_eff: 1'b1,
        p2_mdix_eff: 1'b0,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: 32'h0
      };
    end
    else
    begin
      cur_ff <= nxt_regs;
    end
  end

  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign defaults_loaded = cur_ff.loaded;
  assign p1_manual_flowctl_select = cur_ff.p1_manual_sel;
  assign p1_pause_from_autoneg = cur_ff.p1_pause_auto;
  assign p1_tx_pause_enable = cur_ff.p1_tx_pause;
  assign p1_rx_pause_enable = cur_ff.p1_rx_pause;
  assign p1_sym_pause_advert = cur_ff.p1_sym_pause;
  assign p2_autoneg_enable = cur_ff.p2_an;
  assign p2_speed_select_low = cur_ff.p2_speed;
  assign p2_duplex_select = cur_ff.p2_duplex;
  assign p2_advert_10fd = cur_ff.p2_adv_10fd;
  assign p2_advert_10hd = cur_ff.p2_adv_10hd;
  assign p2_phy_mode = cur_ff.p2_mode;
  assign p2_auto_xover_active = cur_ff.p2_auto_eff;
  assign p2_mdix_select = cur_ff.p2_mdix_eff;
endmodule : psdl_loader

// file: tb/psdl_strap_src.sv
/*
  Strap source model: the six strap pins of the loader, either at their
  documented defaults or at a value the bench chooses.
  Assumes the bench changes cfg only while the loader is in reset,
  except where a test means to wiggle pins after loading.
*/
`timescale 1ns/1ps
`include "psdl_params.svh"

module psdl_strap_src
(
  input wire logic use_dflt,
  input wire logic [5:0] cfg,
  output logic [5:0] pins
);
  // Unstrapped pins sit at their default levels: manual 0, mdix 0, rest 1.
  assign pins = use_dflt ? `PSDL_STRAP_RST : cfg;
endmodule : psdl_strap_src

// file: tb/psdl_loader_props.sv
/*
  Checker of the port strap default loader, bound to its top module.
  Assumes strap pins stay static from reset until the defaults load.
*/
`timescale 1ns/1ps

module psdl_loader_props
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic p1_manual_flowctl_strap,
  input wire logic p1_fullduplex_pause_strap,
  input wire logic p2_auto_xover_strap,
  input wire logic p2_autoneg_strap,
  input wire logic p2_speed_strap,
  input wire logic defaults_loaded,
  input wire logic p1_manual_flowctl_select,
  input wire logic p1_pause_from_autoneg,
  input wire logic p1_tx_pause_enable,
  input wire logic p1_rx_pause_enable,
  input wire logic p1_sym_pause_advert,
  input wire logic p2_autoneg_enable,
  input wire logic p2_speed_select_low,
  input wire logic p2_duplex_select,
  input wire logic p2_advert_10fd,
  input wire logic p2_advert_10hd,
  input wire logic [2:0] p2_phy_mode,
  input wire logic p2_auto_xover_active,
  input wire logic p2_mdix_select
);
  logic wr_done;
  logic [14:0] outs;
  assign wr_done = psel & penable & pready & pwrite;
  assign outs = {p1_manual_flowctl_select, p1_pause_from_autoneg, p1_tx_pause_enable,
    p1_rx_pause_enable, p1_sym_pause_advert, p2_autoneg_enable, p2_speed_select_low,
    p2_duplex_select, p2_advert_10fd, p2_advert_10hd, p2_phy_mode, p2_auto_xover_active,
    p2_mdix_select};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence settling;
    !defaults_loaded [*5];
  endsequence
  sequence loading;
    ##[1:3] defaults_loaded;
  endsequence
  load_time_a: assert property ($rose(presetn) |-> settling ##0 loading)
    else $error("defaults loaded at the wrong time");
  keep_loaded_a: assert property (defaults_loaded |=> defaults_loaded)
    else $error("loaded flag dropped");
  hold_defaults_a: assert property (defaults_loaded && $past(defaults_loaded)
    && !$past(wr_done) |-> $stable(outs)) else $error("defaults moved without a write");
  select_load_a: assert property ($rose(defaults_loaded) |->
    p1_manual_flowctl_select == p1_manual_flowctl_strap) else $error("bad manual select");
  pause_src_a: assert property (p1_pause_from_autoneg != p1_manual_flowctl_select)
    else $error("pause source not inverse of select");
  sym_pause_a: assert property ($rose(defaults_loaded) |->
    p1_sym_pause_advert == !p1_manual_flowctl_strap) else $error("bad sym pause");
  fd_pause_a: assert property ($rose(defaults_loaded) |-> p1_tx_pause_enable ==
    p1_fullduplex_pause_strap && p1_rx_pause_enable == p1_fullduplex_pause_strap)
    else $error("bad pause enables");
  an_speed_a: assert property ($rose(defaults_loaded) |-> p2_autoneg_enable ==
    p2_autoneg_strap && p2_speed_select_low == p2_speed_strap) else $error("bad an or speed");
  mode_field_a: assert property ($rose(defaults_loaded) |-> p2_phy_mode ==
    (p2_autoneg_enable ? 3'h7 : {1'b0, p2_speed_select_low, 1'b1})) else $error("bad mode");
  advert_10_a: assert property ($rose(defaults_loaded) |-> p2_advert_10fd ==
    (p2_autoneg_enable | !p2_speed_select_low) && p2_advert_10hd == p2_advert_10fd)
    else $error("bad 10BASE-T advert");
  auto_xover_a: assert property ($rose(defaults_loaded) |->
    p2_auto_xover_active == p2_auto_xover_strap) else $error("bad auto crossover");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready && !$past(pready))
    else $error("pslverr without pready");
endmodule : psdl_loader_props

bind psdl_loader psdl_loader_props u_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pready(pready),
  .pslverr(pslverr),
  .p1_manual_flowctl_strap(p1_manual_flowctl_strap),
  .p1_fullduplex_pause_strap(p1_fullduplex_pause_strap),
  .p2_auto_xover_strap(p2_auto_xover_strap),
  .p2_autoneg_strap(p2_autoneg_strap),
  .p2_speed_strap(p2_speed_strap),
  .defaults_loaded(defaults_loaded),
  .p1_manual_flowctl_select(p1_manual_flowctl_select),
  .p1_pause_from_autoneg(p1_pause_from_autoneg),
  .p1_tx_pause_enable(p1_tx_pause_enable),
  .p1_rx_pause_enable(p1_rx_pause_enable),
  .p1_sym_pause_advert(p1_sym_pause_advert),
  .p2_autoneg_enable(p2_autoneg_enable),
  .p2_speed_select_low(p2_speed_select_low),
  .p2_duplex_select(p2_duplex_select),
  .p2_advert_10fd(p2_advert_10fd),
  .p2_advert_10hd(p2_advert_10hd),
  .p2_phy_mode(p2_phy_mode),
  .p2_auto_xover_active(p2_auto_xover_active),
  .p2_mdix_select(p2_mdix_select)
);

// file: tb/tb.sv
/*
  Self-checking bench of the port strap default loader: random and
  corner strap sets through reset, APB overrides and refusals.
  Assumes the design and its params header are compiled first.
*/
`timescale 1ns/1ps
`include "psdl_params.svh"

module tb;
  logic pclk, presetn, psel, penable, pwrite, use_dflt, e, loaded;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, seed;
  logic [3:0] pstrb;
  logic pready, pslverr, auto_o, mdix_o, sel_o, fromp_o, tx_o, rx_o;
  logic [5:0] cfg, pins, s;
  wire logic [14:0] outs;
  int err_count, check_count;
  psdl_strap_src u_src (.use_dflt(use_dflt), .cfg(cfg), .pins(pins));
  psdl_loader DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .p1_manual_flowctl_strap(pins[`PSDL_S_P1_MANUAL]),
    .p1_fullduplex_pause_strap(pins[`PSDL_S_P1_FDPAUSE]),
    .p2_auto_xover_strap(pins[`PSDL_S_P2_AUTO]), .p2_manual_xover_strap(pins[`PSDL_S_P2_MANUAL]),
    .p2_autoneg_strap(pins[`PSDL_S_P2_AN]), .p2_speed_strap(pins[`PSDL_S_P2_SPEED]),
    .defaults_loaded(loaded), .p1_manual_flowctl_select(sel_o),
    .p1_pause_from_autoneg(fromp_o), .p1_tx_pause_enable(tx_o), .p1_rx_pause_enable(rx_o),
    .p1_sym_pause_advert(outs[10]), .p2_autoneg_enable(outs[9]),
    .p2_speed_select_low(outs[8]), .p2_duplex_select(outs[7]), .p2_advert_10fd(outs[6]),
    .p2_advert_10hd(outs[5]), .p2_phy_mode(outs[4:2]), .p2_auto_xover_active(auto_o),
    .p2_mdix_select(mdix_o));
  assign outs[14:11] = {sel_o, fromp_o, tx_o, rx_o};
  assign outs[1:0] = {auto_o, mdix_o};

  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  function logic [14:0] exp_out(input logic [5:0] v);
    logic an, sp;
    an = v[`PSDL_S_P2_AN];
    sp = v[`PSDL_S_P2_SPEED];
    return {v[0], !v[0], v[1], v[1], !v[0], an, sp, 1'b1, an | !sp, an | !sp,
      an ? 3'h7 : {1'b0, sp, 1'b1}, v[2], v[3]};
  endfunction : exp_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, pready, 1'b1);
      err_count++;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rst(input logic [5:0] v);
    int n;
    presetn <= 1'b0;
    cfg <= v;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    n = 0;
    while (loaded !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, loaded, 1'b1);
      err_count++;
    end
    @(posedge pclk);
    chk(outs, exp_out(v));
    apb(1'b0, `PSDL_OFS_STRAPS, 32'h0);
    chk(q, {26'h0, v});
    chk(e, 1'b0);
  endtask : rst

  task close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : close_out

  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = !pclk;
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    err_count++;
    close_out;
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hf;
    cfg = 6'h00;
    use_dflt = 1'b1;
    seed = 32'h6bbd;
    err_count = 0;
    check_count = 0;
    @(posedge pclk);
    rst(`PSDL_STRAP_RST);
    use_dflt <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      seed = xs(seed);
      s = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : seed[5:0];
      rst(s);
    end
    $display("strap load test done");
    cfg <= ~s;
    repeat (8) @(posedge pclk);
    chk(outs, exp_out(s));
    apb(1'b1, `PSDL_OFS_P1_FLOWCTL, 32'h1);
    chk(outs[14:11], 4'h8);
    apb(1'b1, `PSDL_OFS_P2_SPECIAL, 32'ha000);
    chk(outs[1:0], 2'h1);
    apb(1'b1, `PSDL_OFS_P2_SPECIAL, 32'hc000);
    chk(outs[1:0], 2'h2);
    // A write whose strobes miss byte 0 must leave the mode field alone.
    pstrb <= 4'he;
    apb(1'b1, `PSDL_OFS_P2_MODES, 32'h5);
    chk(outs[4:2], s[`PSDL_S_P2_AN] ? 3'h7 : {1'b0, s[`PSDL_S_P2_SPEED], 1'b1});
    pstrb <= 4'hf;
    apb(1'b1, `PSDL_OFS_P2_MODES, 32'h5);
    chk(outs[4:2], 3'h5);
    apb(1'b0, `PSDL_OFS_P2_MODES, 32'h0);
    chk({e, q}, {1'b0, 32'h5});
    $display("override test done");
    apb(1'b1, `PSDL_OFS_STRAPS, 32'h0);
    chk(e, 1'b1);
    apb(1'b0, 12'h0f0, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    $display("refusal test done");
    close_out;
  end
endmodule : tb
